// *** core/iest_pkg.sv ***
// Constants, field layouts and carrier types of the instrument event status tree.
`default_nettype none

package iest_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int REG_W   = 16;
    localparam int GEN_W   = 8;
    localparam int NUM_CH  = 2;
    localparam int NUM_STG = 8;
    localparam int ADR_W   = 7;
    localparam int STG_W   = 3;
    localparam int FLD_W   = 3;

    // ------------------------------------------------------------------
    // Query address map
    // ------------------------------------------------------------------
    localparam logic [ADR_W-1:0] ADR_GEN_FLAGS = 7'h00;
    localparam logic [ADR_W-1:0] ADR_GEN_MASK  = 7'h01;
    localparam logic [ADR_W-1:0] ADR_RDY_FLAGS = 7'h02;
    localparam logic [ADR_W-1:0] ADR_RDY_MASK  = 7'h03;
    localparam logic [ADR_W-1:0] ADR_STATUS    = 7'h04;
    localparam int               ADR_STG_BIT   = 6;
    localparam int               ADR_STG_LSB   = 3;

    // Field codes inside one hierarchy stage.
    localparam logic [FLD_W-1:0] FLD_COND = 3'h0;
    localparam logic [FLD_W-1:0] FLD_PTR  = 3'h1;
    localparam logic [FLD_W-1:0] FLD_NTR  = 3'h2;
    localparam logic [FLD_W-1:0] FLD_EVT  = 3'h3;
    localparam logic [FLD_W-1:0] FLD_ENA  = 3'h4;

    // Stage indices: channel summaries, instrument level and top level.
    localparam int STG_OP_CH1   = 0;
    localparam int STG_OP_INSTR = 2;
    localparam int STG_OP_TOP   = 3;
    localparam int STG_QU_CH1   = 4;
    localparam int STG_QU_INSTR = 6;
    localparam int STG_QU_TOP   = 7;

    // ------------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------------
    localparam int GEN_PWR  = 7;
    localparam int GEN_URQ  = 6;
    localparam int GEN_CMD  = 5;
    localparam int GEN_EXE  = 4;
    localparam int GEN_DEV  = 3;
    localparam int GEN_PROT = 2;
    localparam int GEN_CTRL = 1;
    localparam int GEN_OPC  = 0;

    localparam int RDY_STABLE   = 0;
    localparam int RDY_UNSTABLE = 1;
    localparam int RDY_MEAS     = 2;
    localparam int RDY_OVR      = 3;
    localparam int RDY_STRIDE   = 4;

    localparam int OP_RANGE_BIT    = 2;
    localparam int OP_MEAS_BIT     = 4;
    localparam int QU_UNSTABLE_BIT = 9;
    localparam int QU_BAD_DATA_BIT = 14;
    localparam int TOP_SUM_BIT     = 13;

    localparam int SB_OPER  = 7;
    localparam int SB_GEN   = 5;
    localparam int SB_QUES  = 3;
    localparam int SB_READY = 0;

    // ------------------------------------------------------------------
    // Reset values and defined-bit masks
    // ------------------------------------------------------------------
    localparam logic [GEN_W-1:0] GEN_FLAGS_RST = 8'h80;
    localparam logic [REG_W-1:0] PTR_RST       = 16'hffff;
    localparam logic [REG_W-1:0] NTR_RST       = 16'h0000;
    localparam logic [REG_W-1:0] MASK_OP_CH    = 16'h0014;
    localparam logic [REG_W-1:0] MASK_QU_CH    = 16'h4200;
    localparam logic [REG_W-1:0] MASK_INSTR    = 16'h0003;
    localparam logic [REG_W-1:0] MASK_TOP      = 16'h2000;
    localparam logic [REG_W-1:0] STG_MASK [NUM_STG] = '{
        MASK_OP_CH, MASK_OP_CH, MASK_INSTR, MASK_TOP,
        MASK_QU_CH, MASK_QU_CH, MASK_INSTR, MASK_TOP};

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [ADR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } iest_cmd_t;

    typedef struct packed {
        logic user_local;
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic prot_err;
        logic op_done;
    } iest_gen_ev_t;

    typedef struct packed {
        logic meas_done;
        logic overrange;
        logic in_limit;
        logic range_change;
        logic remote_meas;
        logic bad_data;
    } iest_chan_t;

endpackage : iest_pkg

`default_nettype wire

// *** core/iest_status_tree.sv ***
// Event and status reporting tree: general events, transducer ready flags, operation and questionable hierarchy.
`default_nettype none

// Operation
// RQ1 - Eight-bit general event register with power, local, error, control and complete bits.
// RQ2 - General event bits masked by host enable and ORed into a summary.
// RQ3 - Power-cycled flag set by power-up, held until read or cleared.
// RQ4 - User-local flag set when a key press forces local operation.
// RQ5 - Command error flag set on a faulty received command.
// RQ6 - Execution error flag set when a message cannot be carried out.
// RQ7 - Device error flag set on an internal fault such as a timeout.
// RQ8 - Protocol error flag set on a new message with a reply unread.
// RQ9 - Control request flag is never set and reads as zero.
// RQ10 - Operation complete flag set when all requested functions finish.
// RQ11 - Eight-bit ready register of two channels, masked and ORed into summary.
// RQ12 - Measure-done flag set on every finished measurement of that channel.
// RQ13 - Unstable flag set when a reading leaves its stability limit.
// RQ14 - Stable flag set when a reading enters its stability limit.
// RQ15 - Overrange flag set when pressure exceeds the selected range maximum.
// RQ16 - Operation bit 13 set when instrument event bit 0 or 1 set; the code sets it only when one of them is also enabled.
// RQ17 - Instrument bit per channel set by any enabled channel summary event.
// RQ18 - Enabled operation bit 13 forms the operation summary, status bit 7.
// RQ19 - Operation channel condition: bit 2 range change, bit 4 remote measurement.
// RQ20 - Every level: conditions, rising and falling filters, latched events, enable.
// RQ21 - Enabled questionable bit 13 forms the questionable summary, status bit 3.
// RQ22 - Questionable channel condition: bit 9 unstable, bit 14 unusable data.
// RQ23 - General event summary sits at status bit 5.
// RQ24 - Ready summary sits at status bit 0.
// RQ25 - Event registers clear on read; condition and enable registers keep contents.
// RQ26 - Undefined condition, event and summary bits read as zero.

module iest_status_tree
    import iest_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire iest_cmd_t                 cmd_i,
    input  wire logic                      clear_all_i,
    input  wire iest_gen_ev_t              gen_ev_i,
    input  wire iest_chan_t [NUM_CH-1:0]   chan_i,
    output logic                [REG_W-1:0] rdata_o,
    output logic                           rvalid_o,
    output logic                [GEN_W-1:0] status_bits_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Query decode
    // ------------------------------------------------------------------
    // One address bit selects the stage registers; below it sit the flat 8-bit registers.
    wire logic             stg_hit = cmd_i.addr[ADR_STG_BIT];
    wire logic [STG_W-1:0] stg_sel = cmd_i.addr[ADR_STG_LSB +: STG_W];
    wire logic [FLD_W-1:0] fld_sel = cmd_i.addr[FLD_W-1:0];
    wire logic             rd_gen  = cmd_i.rd && (cmd_i.addr == ADR_GEN_FLAGS);
    wire logic             rd_rdy  = cmd_i.rd && (cmd_i.addr == ADR_RDY_FLAGS);
    wire logic             wr_gmsk = cmd_i.wr && (cmd_i.addr == ADR_GEN_MASK);
    wire logic             wr_rmsk = cmd_i.wr && (cmd_i.addr == ADR_RDY_MASK);
    wire logic             clr_gen = rd_gen || clear_all_i;
    wire logic             clr_rdy = rd_rdy || clear_all_i;

    // ------------------------------------------------------------------
    // General event register
    // ------------------------------------------------------------------
    logic [GEN_W-1:0] gen_q;
    logic [GEN_W-1:0] gen_d;
    logic [GEN_W-1:0] gen_set;
    logic [GEN_W-1:0] gen_mask_q;

    always_comb begin
        gen_set           = '0;
        gen_set[GEN_URQ]  = gen_ev_i.user_local;                   // [RQ4]
        gen_set[GEN_CMD]  = gen_ev_i.cmd_err;                      // [RQ5]
        gen_set[GEN_EXE]  = gen_ev_i.exe_err;                      // [RQ6]
        gen_set[GEN_DEV]  = gen_ev_i.dev_err;                      // [RQ7]
        gen_set[GEN_PROT] = gen_ev_i.prot_err;                     // [RQ8]
        gen_set[GEN_CTRL] = 1'b0;                                  // [RQ9]
        gen_set[GEN_OPC]  = gen_ev_i.op_done;                      // [RQ10]
    end

    // A flag raised in the cycle of its clearing read survives.
    assign gen_d = (gen_q & ~{GEN_W{clr_gen}}) | gen_set;        // [RQ1] [RQ25]

    // The power-cycled flag is raised only by reset.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gen_q <= GEN_FLAGS_RST;                                // [RQ3]
        end else begin
            gen_q <= gen_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gen_mask_q <= '0;
        end else if (wr_gmsk) begin
            gen_mask_q <= cmd_i.wdata[GEN_W-1:0];
        end
    end

    wire logic gen_summary = |(gen_q & gen_mask_q);               // [RQ2]

    // ------------------------------------------------------------------
    // Transducer ready register
    // ------------------------------------------------------------------
    logic [GEN_W-1:0]  rdy_q;
    logic [GEN_W-1:0]  rdy_set;
    logic [GEN_W-1:0]  rdy_mask_q;

    // Each channel remembers its last in-limit level to see the limit being crossed.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        logic limit_prev_q;

        // The level starts low, so a reading inside its limit after reset counts as entering it.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                limit_prev_q <= 1'b0;
            end else begin
                limit_prev_q <= chan_i[c].in_limit;
            end
        end

        assign rdy_set[c*RDY_STRIDE+RDY_STABLE]   = chan_i[c].in_limit & ~limit_prev_q;  // [RQ14]
        assign rdy_set[c*RDY_STRIDE+RDY_UNSTABLE] = ~chan_i[c].in_limit & limit_prev_q;  // [RQ13]
        assign rdy_set[c*RDY_STRIDE+RDY_MEAS]     = chan_i[c].meas_done;                 // [RQ12]
        assign rdy_set[c*RDY_STRIDE+RDY_OVR]      = chan_i[c].overrange;                 // [RQ15]
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_q <= '0;
        end else begin
            rdy_q <= (rdy_q & ~{GEN_W{clr_rdy}}) | rdy_set;        // [RQ11] [RQ25]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_mask_q <= '0;
        end else if (wr_rmsk) begin
            rdy_mask_q <= cmd_i.wdata[GEN_W-1:0];
        end
    end

    wire logic rdy_summary = |(rdy_q & rdy_mask_q);               // [RQ11]

    // ------------------------------------------------------------------
    // Operation and questionable hierarchy
    // ------------------------------------------------------------------
    logic [REG_W-1:0]   cond_w    [NUM_STG];
    logic [REG_W-1:0]   cond_m    [NUM_STG];
    logic [REG_W-1:0]   prev_q    [NUM_STG];
    logic [REG_W-1:0]   ptr_q     [NUM_STG];
    logic [REG_W-1:0]   ntr_q     [NUM_STG];
    logic [REG_W-1:0]   evt_q     [NUM_STG];
    logic [REG_W-1:0]   ena_q     [NUM_STG];
    logic [NUM_STG-1:0] stg_sum;

    // Channel conditions feed the lowest level; each level's summary feeds the next.
    always_comb begin
        for (int s = 0; s < NUM_STG; s++) begin
            cond_w[s] = '0;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            cond_w[STG_OP_CH1+c][OP_RANGE_BIT]    = chan_i[c].range_change;  // [RQ19]
            cond_w[STG_OP_CH1+c][OP_MEAS_BIT]     = chan_i[c].remote_meas;   // [RQ19]
            cond_w[STG_QU_CH1+c][QU_UNSTABLE_BIT] = ~chan_i[c].in_limit;     // [RQ22]
            cond_w[STG_QU_CH1+c][QU_BAD_DATA_BIT] = chan_i[c].bad_data;      // [RQ22]
            cond_w[STG_OP_INSTR][c]               = stg_sum[STG_OP_CH1+c];   // [RQ17]
            cond_w[STG_QU_INSTR][c]               = stg_sum[STG_QU_CH1+c];   // [RQ17]
        end
        cond_w[STG_OP_TOP][TOP_SUM_BIT] = stg_sum[STG_OP_INSTR];             // [RQ16]
        cond_w[STG_QU_TOP][TOP_SUM_BIT] = stg_sum[STG_QU_INSTR];             // [RQ16]
    end

    for (genvar s = 0; s < NUM_STG; s++) begin : g_stage
        wire logic             hit     = stg_hit && (stg_sel == STG_W'(s));
        wire logic             wr_ptr  = cmd_i.wr && hit && (fld_sel == FLD_PTR);
        wire logic             wr_ntr  = cmd_i.wr && hit && (fld_sel == FLD_NTR);
        wire logic             wr_ena  = cmd_i.wr && hit && (fld_sel == FLD_ENA);
        wire logic             rd_evt  = cmd_i.rd && hit && (fld_sel == FLD_EVT);
        wire logic [REG_W-1:0] rise    = cond_m[s] & ~prev_q[s] & ptr_q[s];
        wire logic [REG_W-1:0] fall    = ~cond_m[s] & prev_q[s] & ntr_q[s];
        wire logic [REG_W-1:0] evt_clr = {REG_W{rd_evt || clear_all_i}};

        // Undefined bits are cut here, so they reach no event, no summary and no reply.
        assign cond_m[s]  = cond_w[s] & STG_MASK[s];                        // [RQ26]
        assign stg_sum[s] = |(evt_q[s] & ena_q[s]);                         // [RQ20]

        // A new edge in the cycle of a clearing read or a clear-all is kept.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                prev_q[s] <= '0;
                evt_q[s]  <= '0;
            end else begin
                prev_q[s] <= cond_m[s];
                evt_q[s]  <= (evt_q[s] & ~evt_clr) | rise | fall;          // [RQ20] [RQ25]
            end
        end

        // Out of reset the filters pass every rising edge and no falling one.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ptr_q[s] <= PTR_RST & STG_MASK[s];
                ntr_q[s] <= NTR_RST;
            end else begin
                if (wr_ptr) begin
                    ptr_q[s] <= cmd_i.wdata & STG_MASK[s];                 // [RQ26]
                end
                if (wr_ntr) begin
                    ntr_q[s] <= cmd_i.wdata & STG_MASK[s];
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ena_q[s] <= '0;
            end else if (wr_ena) begin
                ena_q[s] <= cmd_i.wdata & STG_MASK[s];
            end
        end
    end

    // Only the summary bit of each top stage leaves the hierarchy.
    wire logic oper_summary = stg_sum[STG_OP_TOP];                // [RQ18]
    wire logic ques_summary = stg_sum[STG_QU_TOP];                // [RQ21]

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    logic [GEN_W-1:0] status_d;

    // Summaries are registered once more, so a status read sees a settled byte.
    always_comb begin
        status_d           = '0;
        status_d[SB_OPER]  = oper_summary;                         // [RQ18]
        status_d[SB_GEN]   = gen_summary;                          // [RQ23]
        status_d[SB_QUES]  = ques_summary;                         // [RQ21]
        status_d[SB_READY] = rdy_summary;                          // [RQ24]
    end

    // ------------------------------------------------------------------
    // Query reply
    // ------------------------------------------------------------------
    logic [REG_W-1:0] rdata_d;
    logic [REG_W-1:0] stg_rd;
    logic [REG_W-1:0] rdata_q;
    logic             rvalid_q;
    logic [GEN_W-1:0] status_q;

    always_comb begin
        case (fld_sel)
            FLD_COND: stg_rd = cond_m[stg_sel];
            FLD_PTR:  stg_rd = ptr_q[stg_sel];
            FLD_NTR:  stg_rd = ntr_q[stg_sel];
            FLD_EVT:  stg_rd = evt_q[stg_sel];
            FLD_ENA:  stg_rd = ena_q[stg_sel];
            default:  stg_rd = '0;
        endcase
    end

    // Unmapped addresses answer zero.
    always_comb begin
        rdata_d = '0;
        if (stg_hit) begin
            rdata_d = stg_rd;
        end else begin
            case (cmd_i.addr)
                ADR_GEN_FLAGS: rdata_d = {{(REG_W-GEN_W){1'b0}}, gen_q};
                ADR_GEN_MASK:  rdata_d = {{(REG_W-GEN_W){1'b0}}, gen_mask_q};
                ADR_RDY_FLAGS: rdata_d = {{(REG_W-GEN_W){1'b0}}, rdy_q};
                ADR_RDY_MASK:  rdata_d = {{(REG_W-GEN_W){1'b0}}, rdy_mask_q};
                ADR_STATUS:    rdata_d = {{(REG_W-GEN_W){1'b0}}, status_q};
                default:       rdata_d = '0;
            endcase
        end
    end

    // The reply register holds its value until the next read.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (cmd_i.rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            status_q <= '0;
        end else begin
            rvalid_q <= cmd_i.rd;
            status_q <= status_d;
        end
    end

    assign rdata_o       = rdata_q;
    assign rvalid_o      = rvalid_q;
    assign status_bits_o = status_q;

endmodule : iest_status_tree

`default_nettype wire

// *** tb/iest_status_tree_props.sv ***
// Concurrent checks on the ports of the event status tree.
`default_nettype none

module iest_status_tree_props
    import iest_pkg::*;
(
    input wire logic                    clk_i,
    input wire logic                    rst_n_i,
    input wire iest_cmd_t               cmd_i,
    input wire logic                    clear_all_i,
    input wire iest_gen_ev_t            gen_ev_i,
    input wire iest_chan_t [NUM_CH-1:0] chan_i,
    input wire logic [REG_W-1:0]        rdata_o,
    input wire logic                    rvalid_o,
    input wire logic [GEN_W-1:0]        status_bits_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    wire rd_gen = cmd_i.rd && (cmd_i.addr == ADR_GEN_FLAGS);
    wire rd_rdy = cmd_i.rd && (cmd_i.addr == ADR_RDY_FLAGS);

    property p_rvalid; 1'b1 |=> rvalid_o == $past(cmd_i.rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer pulse misplaced");
    property p_ctrl_zero; rd_gen |=> !rdata_o[GEN_CTRL] && rdata_o[REG_W-1:GEN_W] == '0; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control request bit set");
    property p_read_clear;
        (rd_gen && gen_ev_i == '0) ##1 (gen_ev_i == '0) ##1 rd_gen |=> rdata_o == '0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("general flags kept after read");
    property p_clear_all;
        (clear_all_i && gen_ev_i == '0) ##1 (gen_ev_i == '0) ##1 rd_gen |=> rdata_o == '0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("general flags kept after clear");
    property p_cmd_err;
        gen_ev_i.cmd_err ##1 (!cmd_i.rd && !clear_all_i) ##1 rd_gen |=> rdata_o[GEN_CMD];
    endproperty
    a_cmd_err: assert property (p_cmd_err) else $error("command error flag missing");
    property p_meas;
        chan_i[0].meas_done ##1 (!cmd_i.rd && !clear_all_i) ##1 rd_rdy |=> rdata_o[RDY_MEAS];
    endproperty
    a_meas: assert property (p_meas) else $error("measure done flag missing");
    property p_ovr2;
        chan_i[1].overrange ##1 (!cmd_i.rd && !clear_all_i) ##1 rd_rdy |=> rdata_o[RDY_STRIDE+RDY_OVR];
    endproperty
    a_ovr2: assert property (p_ovr2) else $error("overrange flag missing");
    property p_op_cond;
        (chan_i[0].remote_meas && chan_i[0].range_change)[*3] ##0 (cmd_i.rd && cmd_i.addr == 7'h40)
            |=> rdata_o == MASK_OP_CH;
    endproperty
    a_op_cond: assert property (p_op_cond) else $error("operation condition wrong");
    property p_qu_cond;
        (!chan_i[0].in_limit && chan_i[0].bad_data)[*3] ##0 (cmd_i.rd && cmd_i.addr == 7'h60)
            |=> rdata_o == MASK_QU_CH;
    endproperty
    a_qu_cond: assert property (p_qu_cond) else $error("questionable condition wrong");
    property p_sb_undef; 1'b1 |-> (status_bits_o & 8'h56) == '0; endproperty
    a_sb_undef: assert property (p_sb_undef) else $error("undefined status bit set");

endmodule : iest_status_tree_props

bind iest_status_tree iest_status_tree_props i_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .clear_all_i(clear_all_i), .gen_ev_i(gen_ev_i),
    .chan_i(chan_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .status_bits_o(status_bits_o));

`default_nettype wire

// *** tb/iest_host_model.sv ***
// Behavioural remote host that issues queries to the event status tree.
`default_nettype none

module iest_host_model
    import iest_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rvalid_i,
    input  wire logic [REG_W-1:0] rdata_i,
    output var  iest_cmd_t        cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd_o = '0;

    // A missing answer returns unknown data so that the caller's compare fails.
    task automatic access(input logic rd, input logic wr, input logic [ADR_W-1:0] a,
                          input logic [REG_W-1:0] d, output logic [REG_W-1:0] q);
        @(posedge clk_i);
        cmd_o <= '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge clk_i);
        cmd_o <= '0;
        #1;
        q = rvalid_i ? rdata_i : {REG_W{1'bx}};
    endtask : access

endmodule : iest_host_model

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench of the event status tree.
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_top
    import iest_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk   = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    clr   = 1'b0;
    iest_gen_ev_t            gev   = '0;
    iest_chan_t [NUM_CH-1:0] ch    = '0;
    iest_cmd_t               cmd;
    logic [REG_W-1:0]        rdata;
    logic                    rvalid;
    logic [GEN_W-1:0]        sb;
    int                      mismatches = 0;
    int                      checks     = 0;

    always #5 clk = ~clk;

    iest_status_tree i_dut (.clk_i(clk), .rst_n_i(rst_n), .cmd_i(cmd), .clear_all_i(clr), .gen_ev_i(gev),
        .chan_i(ch), .rdata_o(rdata), .rvalid_o(rvalid), .status_bits_o(sb));
    iest_host_model i_host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .cmd_o(cmd));

    // ------------------------------------------------------------------
    // Shared access tasks
    // ------------------------------------------------------------------
    function automatic logic [ADR_W-1:0] sa(input int s, input int f);
        return ADR_W'(8'h40 | (s << 3) | f);
    endfunction : sa
    task automatic rchk(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] e);
        logic [REG_W-1:0] q;
        i_host.access(1'b1, 1'b0, a, '0, q);
        `CHK(q, e)
    endtask : rchk
    task automatic wr(input logic [ADR_W-1:0] a, input logic [REG_W-1:0] d);
        logic [REG_W-1:0] q;
        i_host.access(1'b0, 1'b1, a, d, q);
    endtask : wr
    task automatic sbchk(input int b, input logic e);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (sb[b] === e) break;
        end
        `CHK(sb[b], e)
    endtask : sbchk
    task automatic gpulse(input iest_gen_ev_t v);
        @(posedge clk);
        gev <= v;
        @(posedge clk);
        gev <= '0;
    endtask : gpulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power;
        rchk(ADR_GEN_FLAGS, 16'h0080);
        rchk(ADR_GEN_FLAGS, 16'h0000);
        rchk(ADR_STATUS, 16'h0000);
        rchk(7'h05, 16'h0000);
    endtask : t_power
    task automatic t_gen;
        for (int k = 0; k < 6; k++) begin
            gpulse(iest_gen_ev_t'(6'(1 << k)));
            rchk(ADR_GEN_FLAGS, 16'(1 << (k == 0 ? 0 : k + 1)));
        end
        wr(ADR_GEN_MASK, 16'hff20);
        rchk(ADR_GEN_MASK, 16'h0020);
        gpulse('{exe_err: 1'b1, default: 1'b0});
        repeat (4) @(posedge clk);
        sbchk(SB_GEN, 1'b0);
        gpulse('{cmd_err: 1'b1, default: 1'b0});
        sbchk(SB_GEN, 1'b1);
        wr(ADR_GEN_FLAGS, 16'h0000);
        rchk(ADR_GEN_FLAGS, 16'h0030);
        sbchk(SB_GEN, 1'b0);
        gpulse('{op_done: 1'b1, default: 1'b0});
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        rchk(ADR_GEN_FLAGS, 16'h0000);
    endtask : t_gen
    task automatic t_ready;
        wr(ADR_RDY_MASK, 16'h0080);
        @(posedge clk);
        ch[0].in_limit <= 1'b1;
        ch[0].meas_done <= 1'b1;
        ch[1].overrange <= 1'b1;
        @(posedge clk);
        ch[0].meas_done <= 1'b0;
        ch[1].overrange <= 1'b0;
        rchk(ADR_RDY_FLAGS, 16'h0085);
        @(posedge clk);
        ch[0].in_limit <= 1'b0;
        ch[1].overrange <= 1'b1;
        @(posedge clk);
        ch[1].overrange <= 1'b0;
        sbchk(SB_READY, 1'b1);
        rchk(ADR_RDY_FLAGS, 16'h0082);
        sbchk(SB_READY, 1'b0);
    endtask : t_ready
    task automatic t_hier;
        wr(sa(STG_OP_CH1, 4), 16'hffff);
        rchk(sa(STG_OP_CH1, 4), MASK_OP_CH);
        wr(sa(STG_OP_INSTR, 4), 16'h0001);
        wr(sa(STG_OP_TOP, 4), 16'h2000);
        @(posedge clk);
        ch[0].remote_meas <= 1'b1;
        ch[0].range_change <= 1'b1;
        sbchk(SB_OPER, 1'b1);
        rchk(sa(STG_OP_CH1, 0), MASK_OP_CH);
        rchk(sa(STG_OP_TOP, 0), 16'h2000);
        rchk(sa(STG_OP_CH1, 3), MASK_OP_CH);
        rchk(sa(STG_OP_CH1, 3), 16'h0000);
        wr(sa(STG_OP_CH1, 1), 16'h0000);
        wr(sa(STG_OP_CH1, 2), 16'h0010);
        @(posedge clk);
        ch[0].remote_meas <= 1'b0;
        ch[0].range_change <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(sa(STG_OP_CH1, 3), 16'h0010);
        rchk(sa(STG_QU_CH1, 3), 16'h0200);
        wr(sa(STG_QU_CH1, 4), 16'h4000);
        wr(sa(STG_QU_INSTR, 4), 16'h0001);
        wr(sa(STG_QU_TOP, 4), 16'h2000);
        sbchk(SB_QUES, 1'b0);
        @(posedge clk);
        ch[0].bad_data <= 1'b1;
        sbchk(SB_QUES, 1'b1);
        rchk(sa(STG_QU_CH1, 0), MASK_QU_CH);
    endtask : t_hier

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_power();
        t_gen();
        t_ready();
        t_hier();
        report_and_stop();
    end

    initial begin
        #50us;
        mismatches++;
        report_and_stop();
    end

endmodule : tb_top

`default_nettype wire
